// File: src/buckboost_pkg.sv
package buckboost_pkg;

  localparam int CLK_KHZ = 50000;
  localparam int CLK_NS = 20;
  localparam int OSC_KHZ = 400;
  localparam int OSC_CYCLES = CLK_KHZ / OSC_KHZ;
  localparam int DEAD_NS = 60;
  localparam int DEAD_CYCLES = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_ON_PCT = 15;
  localparam int A_ON_PCT = 85;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PERIOD_ADDR = 8'h04;
  localparam logic [7:0] DEAD_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_SKIP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] PERIOD_RESET = 16'(OSC_CYCLES);
  localparam logic [7:0] DEAD_RESET = 8'(DEAD_CYCLES);

  localparam int STAT_GATES_LSB = 0;
  localparam int STAT_CTL_LSB = 4;
  localparam int STAT_PWR_LSB = 6;

  typedef enum logic [1:0] {cs_buck, cs_pbuck_bb, cs_pboost_bb, cs_boost} ctl_e;
  typedef enum logic [1:0] {ps_off, ps_lock, ps_por, ps_run} pwr_e;

  typedef struct packed {
    logic enable_lockout_in;
    logic enable_rising_ok;
    logic internal_supply_ok;
    logic thermal_ok;
    logic reference_ok;
    logic buck_peak_comparator;
    logic boost_peak_comparator;
    logic buck_reverse;
    logic boost_reverse;
    logic feedback_in_over;
    logic light_load;
    logic sync_spread_in;
    ctl_e region_sel;
  } sense_s;

  typedef struct packed {
    logic hi;
    logic lo;
    logic [7:0] dead;
  } leg_s;

endpackage : buckboost_pkg

// File: src/buckboost_sequencer.sv
// What this block does
// - exactly one of four control states
// - region changes need two agreeing cycle starts
// - buck: C off, D on, A/B alternate
// - peak-buck bb: A+C, C to D at 15%
// - buck peak trip in A+D: A off, B on
// - peak-boost bb: boost trip C to D, A off at 85%
// - boost: A on, B off, C then D
// - dead time on A/B and C/D changeover
// - buck: buck reverse in B+D turns B off
// - boost: boost reverse in A+D turns D off
// - bb: reverse trips turn D or B+D off
// - light load: DCM or skip whole cycles
// - buck or boost logic owns the peak trip, never both; bb states act on both reverse trips
// - below shutdown threshold: all off, regulator off
// - above shutdown: wake, lockout with hysteresis current
// - enable mode needs supply, enable, temperature; hysteresis off
// - power-on reset until reference ok, then switch
// - sync rising edge starts a switching cycle
// - feedback overvoltage turns off all gates
// - lockout or thermal event stops switching, discharges soft-start
`timescale 1ns/100ps
module buckboost_sequencer
(
  input wire logic clk,
  input wire logic reset,
  input wire buckboost_pkg::sense_s pins,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic switch_a_gate,
  output logic switch_b_gate,
  output logic switch_c_gate,
  output logic switch_d_gate,
  output logic regulator_on,
  output logic hysteresis_current_on,
  output logic soft_start_discharge
);
  import buckboost_pkg::*;

  typedef struct packed {
    sense_s s1;
    sense_s s2;
    logic sync_prev;
    pwr_e pwr;
    ctl_e ctl;
    ctl_e cand;
    logic [15:0] cnt;
    logic peak;
    logic rev_d;
    logic rev_bd;
    logic skip;
    leg_s ab;
    leg_s dc;
    logic [1:0] ctrl;
    logic [15:0] period;
    logic [7:0] dead;
    logic ack;
    logic [31:0] dat;
    logic reg_on;
    logic hyst_on;
    logic ss_dis;
  } state_s;

  state_s q;
  state_s d;

  function automatic logic [15:0] pct(input logic [15:0] p, input int n);
    logic [22:0] prod;
    prod = 23'(p) * 23'(n);
    return 16'(prod / 23'd100);
  endfunction : pct

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic leg_s leg_step(input leg_s l, input logic wh, input logic wl, input logic [7:0] dt);
    leg_s n;
    n = l;
    if ((l.hi && !wh) || (l.lo && !wl))
    begin
      n.hi = 1'b0;
      n.lo = 1'b0;
      n.dead = dt;
    end
    else if (l.dead != 8'h00)
    begin
      n.dead = l.dead - 8'h01;
    end
    else
    begin
      n.hi = wh && !l.lo && !wl;
      n.lo = wl && !l.hi && !wh;
    end
    return n;
  endfunction : leg_step

  logic cyc_start;
  logic sync_edge;
  logic tick;
  logic enable_ok;
  logic switching;
  logic peak_cmp;
  logic [15:0] c_end;
  logic [15:0] a_end;
  logic [7:0] dt;
  logic wa;
  logic wb;
  logic wc;
  logic wd;

  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.sync_prev = q.s2.sync_spread_in;
    sync_edge = q.s2.sync_spread_in && !q.sync_prev;
    tick = q.cnt >= q.period - 16'h0001;
    cyc_start = q.ctrl[CTRL_SYNC_BIT] ? sync_edge : tick;
    c_end = pct(q.period, C_ON_PCT);
    a_end = pct(q.period, A_ON_PCT);
    dt = (q.dead == 8'h00) ? 8'h01 : q.dead;
    enable_ok = q.s2.internal_supply_ok && q.s2.enable_rising_ok && q.s2.thermal_ok;

    // power sequence
    case (q.pwr)
      ps_off: if (q.s2.enable_lockout_in) d.pwr = ps_lock;
      ps_lock: if (enable_ok) d.pwr = ps_por;
      ps_por: if (!enable_ok) d.pwr = ps_lock; else if (q.s2.reference_ok) d.pwr = ps_run;
      ps_run: if (!enable_ok) d.pwr = ps_lock;
      default: d.pwr = ps_off;
    endcase
    if (!q.s2.enable_lockout_in)
    begin
      d.pwr = ps_off;
    end
    d.reg_on = d.pwr != ps_off;
    d.hyst_on = d.pwr == ps_lock;
    d.ss_dis = d.pwr != ps_run;

    // cycle timing and per-cycle flags
    if (cyc_start)
    begin
      d.cnt = 16'h0000;
      d.peak = 1'b0;
      d.rev_d = 1'b0;
      d.rev_bd = 1'b0;
      d.skip = q.ctrl[CTRL_SKIP_BIT] && q.s2.light_load;
      d.cand = q.s2.region_sel;
      if (q.s2.region_sel == q.cand)
      begin
        d.ctl = q.cand;
      end
    end
    else if (q.cnt != 16'hffff)
    begin
      d.cnt = q.cnt + 16'h0001;
    end

    // buck logic owns peak in buck states, boost logic otherwise
    peak_cmp = (q.ctl == cs_buck || q.ctl == cs_pbuck_bb) ?
      q.s2.buck_peak_comparator && switch_a_gate && switch_d_gate :
      q.s2.boost_peak_comparator && switch_a_gate && switch_c_gate;
    if (!cyc_start && peak_cmp)
    begin
      d.peak = 1'b1;
    end
    if (!cyc_start && q.s2.boost_reverse && switch_a_gate && switch_d_gate && q.ctl != cs_buck)
    begin
      d.rev_d = 1'b1;
    end
    if (!cyc_start && q.s2.buck_reverse && switch_b_gate && switch_d_gate && q.ctl != cs_boost)
    begin
      d.rev_bd = 1'b1;
    end

    // wanted gates per control state
    case (q.ctl)
      cs_buck:
      begin
        wa = !q.peak;
        wb = q.peak && !q.rev_bd;
        wc = 1'b0;
        wd = 1'b1;
      end
      cs_pbuck_bb:
      begin
        wc = q.cnt < c_end;
        wa = !q.peak;
        wb = q.peak && !q.rev_bd;
        wd = !wc && !q.rev_d && !q.rev_bd;
      end
      cs_pboost_bb:
      begin
        wa = q.cnt < a_end;
        wb = !wa && !q.rev_bd;
        wc = !q.peak;
        wd = q.peak && !q.rev_d && !q.rev_bd;
      end
      cs_boost:
      begin
        wa = 1'b1;
        wb = 1'b0;
        wc = !q.peak;
        wd = q.peak && !q.rev_d;
      end
      default:
      begin
        wa = 1'b0;
        wb = 1'b0;
        wc = 1'b0;
        wd = 1'b0;
      end
    endcase
    switching = q.pwr == ps_run && !q.s2.feedback_in_over && !q.skip;
    d.ab = leg_step(q.ab, wa && switching, wb && switching, dt);
    d.dc = leg_step(q.dc, wd && switching, wc && switching, dt);

    // wishbone classic slave, one wait state
    d.ack = wb_cyc && wb_stb && !q.ack;
    d.dat = 32'h0000_0000;
    if (wb_cyc && wb_stb && !q.ack)
    begin
      case (wb_adr)
        CTRL_ADDR: d.dat = {30'h0, q.ctrl};
        PERIOD_ADDR: d.dat = {16'h0, q.period};
        DEAD_ADDR: d.dat = {24'h0, q.dead};
        STATUS_ADDR:
        begin
          d.dat[STAT_GATES_LSB +: 4] = {switch_a_gate, switch_b_gate, switch_c_gate, switch_d_gate};
          d.dat[STAT_CTL_LSB +: 2] = q.ctl;
          d.dat[STAT_PWR_LSB +: 2] = q.pwr;
        end
        default: d.dat = 32'h0000_0000;
      endcase
    end
    if (wb_cyc && wb_stb && wb_we && q.ack)
    begin
      case (wb_adr)
        CTRL_ADDR: d.ctrl = 2'(merge({30'h0, q.ctrl}, wb_dat_w, wb_sel));
        PERIOD_ADDR: d.period = 16'(merge({16'h0, q.period}, wb_dat_w, wb_sel));
        DEAD_ADDR: d.dead = 8'(merge({24'h0, q.dead}, wb_dat_w, wb_sel));
        default: d.ctrl = q.ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.period <= PERIOD_RESET;
      q.dead <= DEAD_RESET;
      q.ss_dis <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign switch_a_gate = q.ab.hi;
  assign switch_b_gate = q.ab.lo;
  assign switch_d_gate = q.dc.hi;
  assign switch_c_gate = q.dc.lo;
  assign regulator_on = q.reg_on;
  assign hysteresis_current_on = q.hyst_on;
  assign soft_start_discharge = q.ss_dis;
  assign wb_ack = q.ack;
  assign wb_dat_r = q.dat;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ab_no_overlap_a: assert property ($fell(q.ab.hi) |-> !q.ab.lo ##1 !q.ab.lo)
    else $error("a to b changeover without dead time");
  dc_no_overlap_a: assert property ($fell(q.dc.lo) |-> !q.dc.hi ##1 !q.dc.hi)
    else $error("c to d changeover without dead time");
  buck_c_off_a: assert property (q.ctl == cs_buck && $past(q.ctl) == cs_buck |-> !q.dc.lo)
    else $error("switch c on in buck region");
  boost_b_off_a: assert property (q.ctl == cs_boost && $past(q.ctl) == cs_boost |-> !q.ab.lo)
    else $error("switch b on in boost region");
  shutdown_quiet_a: assert property (q.pwr == ps_off |-> !q.reg_on ##1 !(q.ab.hi || q.dc.hi))
    else $error("activity in shutdown");
  por_no_switch_a: assert property (q.pwr == ps_por |=> !(q.ab.hi || q.ab.lo || q.dc.hi || q.dc.lo))
    else $error("switching during power-on reset");
  overvoltage_off_a: assert property (q.s2.feedback_in_over |=> !(q.ab.hi || q.ab.lo || q.dc.hi || q.dc.lo))
    else $error("gate on during overvoltage");
  lockout_hold_a: assert property (q.pwr == ps_lock && !enable_ok |=> q.pwr != ps_por)
    else $error("enable mode entered without conditions");
  region_stable_a: assert property (!cyc_start |=> $stable(q.ctl))
    else $error("region changed inside a cycle");

  bb_peak_c: cover property (q.ctl == cs_pbuck_bb && $rose(q.peak));
  boost_bb_c: cover property (q.ctl == cs_pboost_bb && $rose(q.ab.lo));
  run_entry_c: cover property ($rose(q.pwr == ps_run));
  skip_c: cover property ($rose(q.skip));

endmodule : buckboost_sequencer

// File: dv/power_stage_model.sv
`timescale 1ns/100ps
module power_stage_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] gates,
  input wire logic rise_ad,
  input wire logic [7:0] peak,
  output logic buck_peak,
  output logic boost_peak,
  output logic buck_rev,
  output logic boost_rev
);
  logic [7:0] il_q;
  logic a, b, c, d;
  assign {a, b, c, d} = gates;
  // inductor current: up while charging, down while discharging
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      il_q <= 8'h00;
    else if (il_q != 8'hff && ((a && c) || (a && d && rise_ad)))
      il_q <= il_q + 8'h01;
    else if (il_q != 8'h00 && ((b && d) || (a && d && !rise_ad)))
      il_q <= il_q - 8'h01;
  end
  assign buck_peak = a && d && il_q >= peak;
  assign boost_peak = a && c && il_q >= peak;
  assign buck_rev = b && d && il_q == 8'h00;
  assign boost_rev = a && d && !rise_ad && il_q == 8'h00;
endmodule : power_stage_model

// File: dv/four_switch_buck_boost_sequencer_bench.sv
`timescale 1ns/100ps
module four_switch_buck_boost_sequencer_bench;
  import buckboost_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  sense_s drv = '0;
  sense_s pins_w;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic [31:0] q;
  logic wb_ack, ga, gb, gc, gd, reg_on, hyst_on, ss_dis;
  logic rise_ad = 1'b0;
  logic sync = 1'b0;
  logic sync_on = 1'b0;
  logic watch = 1'b0;
  logic [3:0] ever, held;
  logic bpk, opk, brv, orv;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  initial
  begin
    forever #10 clk = ~clk;
  end

  always_comb
  begin
    pins_w = drv;
    pins_w.buck_peak_comparator = bpk;
    pins_w.boost_peak_comparator = opk;
    pins_w.buck_reverse = brv;
    pins_w.boost_reverse = orv;
    pins_w.sync_spread_in = sync;
  end

  buckboost_sequencer dut (.clk(clk), .reset(reset), .pins(pins_w), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .switch_a_gate(ga), .switch_b_gate(gb), .switch_c_gate(gc), .switch_d_gate(gd), .regulator_on(reg_on),
    .hysteresis_current_on(hyst_on), .soft_start_discharge(ss_dis));

  power_stage_model stage (.clk(clk), .reset(reset), .gates({ga, gb, gc, gd}), .rise_ad(rise_ad),
    .peak(8'h0a), .buck_peak(bpk), .boost_peak(opk), .buck_rev(brv), .boost_rev(orv));

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task conclude;
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    sync <= sync_on && (cycles % 50 < 25);
    if ((ga && gb) || (gc && gd))
      check("overlap", 32'h0, 32'h1);
    ever <= watch ? (ever | {ga, gb, gc, gd}) : 4'h0;
    held <= watch ? (held & {ga, gb, gc, gd}) : 4'hf;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do
    begin
      @(posedge clk);
    end
    while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : xfer

  task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h0);
    check(name, exp, q & mask);
  endtask : rd

  task region(input ctl_e r, input logic up, input logic [3:0] e_ever, input logic [3:0] e_held);
    drv.region_sel <= r;
    rise_ad <= up;
    repeat (160) @(posedge clk);
    watch <= 1'b1;
    repeat (200) @(posedge clk);
    watch <= 1'b0;
    check("ever_on", 32'(e_ever), 32'(ever));
    check("held_on", 32'(e_held), 32'(held));
  endtask : region

  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("gates", 32'h0, 32'({ga, gb, gc, gd}));
    check("ss_dis", 32'h1, 32'(ss_dis));
    rd(PERIOD_ADDR, 32'hffff, 32'(PERIOD_RESET), "period");
    rd(DEAD_ADDR, 32'hff, 32'(DEAD_RESET), "dead");
    rd(CTRL_ADDR, 32'h3, 32'h0, "ctrl");
    rd(8'h10, 32'hffffffff, 32'h0, "unmapped");
    xfer(1'b1, PERIOD_ADDR, 32'h28);
    rd(PERIOD_ADDR, 32'hffff, 32'h28, "period_wr");
    xfer(1'b1, STATUS_ADDR, 32'hff);
    rd(STATUS_ADDR, 32'hcf, 32'h0, "status_off");
    drv.enable_lockout_in <= 1'b1;
    repeat (8) @(posedge clk);
    check("reg_on", 32'h1, 32'(reg_on));
    check("hyst_on", 32'h1, 32'(hyst_on));
    rd(STATUS_ADDR, 32'hcf, 32'h40, "status_lock");
    drv.internal_supply_ok <= 1'b1;
    drv.enable_rising_ok <= 1'b1;
    drv.thermal_ok <= 1'b1;
    repeat (8) @(posedge clk);
    check("hyst_off", 32'h0, 32'(hyst_on));
    check("gates_por", 32'h0, 32'({ga, gb, gc, gd}));
    rd(STATUS_ADDR, 32'hc0, 32'h80, "status_por");
    drv.reference_ok <= 1'b1;
    repeat (8) @(posedge clk);
    rd(STATUS_ADDR, 32'hc0, 32'hc0, "status_run");
    region(cs_buck, 1'b1, 4'hd, 4'h1);
    region(cs_pbuck_bb, 1'b1, 4'hf, 4'h0);
    region(cs_pboost_bb, 1'b0, 4'hf, 4'h0);
    region(cs_boost, 1'b0, 4'hb, 4'h8);
    xfer(1'b1, CTRL_ADDR, 32'h1);
    sync_on <= 1'b1;
    region(cs_buck, 1'b1, 4'hd, 4'h1);
    sync_on <= 1'b0;
    region(cs_buck, 1'b1, 4'h1, 4'h1);
    xfer(1'b1, CTRL_ADDR, 32'h2);
    drv.light_load <= 1'b1;
    region(cs_buck, 1'b1, 4'h0, 4'h0);
    drv.light_load <= 1'b0;
    drv.feedback_in_over <= 1'b1;
    region(cs_buck, 1'b1, 4'h0, 4'h0);
    drv.feedback_in_over <= 1'b0;
    repeat (100) @(posedge clk);
    drv.thermal_ok <= 1'b0;
    repeat (8) @(posedge clk);
    check("gates_hot", 32'h0, 32'({ga, gb, gc, gd}));
    check("ss_hot", 32'h1, 32'(ss_dis));
    rd(STATUS_ADDR, 32'hc0, 32'h40, "status_hot");
    drv.enable_lockout_in <= 1'b0;
    repeat (8) @(posedge clk);
    check("reg_off", 32'h0, 32'(reg_on));
    conclude();
  end
endmodule : four_switch_buck_boost_sequencer_bench
